//--- hw/pcf_flags.sv
`timescale 1ns/100ps
`include "pcf_cfg.svh"

module pcf_flags
    import pcf_pkg::*;
(
    input wire logic sys_clk, // 250 MHz core clock
    input wire logic sys_rst, // synchronous reset, active high
    input wire logic mov_wr, // move-to-control-register strobe
    input wire pcf_sel_t mov_sel, // control register selected
    input wire logic [31:0] mov_wdata, // value to write
    output logic [31:0] mov_rdata_q, // value read by move-from
    input wire pcf_instr_t instr, // decoded instruction event
    input wire logic fpu_present, // coprocessor fitted, strap level
    input wire logic task_switch, // task switch event
    input wire logic hw_error, // hardware error condition
    input wire logic align_check_flag, // alignment_check_flag of the flags word
    input wire logic misaligned, // current access unaligned
    input wire logic unpaged_cycle, // bus cycle not translated
    output pcf_fault_t fault_q, // fault raised, one cycle
    output logic [15:0] fcw_q, // control word store result
    output logic wait_ts_fault_q, // waiting instruction hit task switch
    output logic tlb_flush_q, // flush request pulse
    output logic tlb_keep_global_q, // flush spares global entries
    output pcf_ctrl_t ctrl_q, // derived feature controls
    output logic page_cache_pin_q, // page_cache_pin drive
    output logic write_through_pin_q, // write_through_pin drive
    output logic pins_oe_q // page pins driven from the register
);

    // ----------------------------------------------------------------
    // strap synchroniser
    // ----------------------------------------------------------------
    logic fpu_meta_q;
    logic fpu_sync_q;
    logic fpu_seen_q;

    // presence comes from a board pin, so two stages before use
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            fpu_meta_q <= 1'b0;
            fpu_sync_q <= 1'b0;
        end
        else
        begin
            fpu_meta_q <= fpu_present;
            fpu_sync_q <= fpu_meta_q;
        end
    end

    // ----------------------------------------------------------------
    // control registers
    // ----------------------------------------------------------------
    logic [31:0] cr0_q;
    logic [31:0] cr3_q;
    logic [31:0] cr4_q;

    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            cr0_q <= `PCF_CR0_RST;
            cr3_q <= `PCF_CR3_RST;
            cr4_q <= `PCF_CR4_RST;
        end
        else if (mov_wr)
        begin
            unique case (mov_sel)
                PCF_SEL_CR0: cr0_q <= mov_wdata;
                PCF_SEL_CR3: cr3_q <= mov_wdata;
                PCF_SEL_CR4: cr4_q <= mov_wdata & `PCF_CR4_WMASK;
                PCF_SEL_NONE: ;
            endcase
        end
    end

    // move-from returns the selected register a cycle later
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
            mov_rdata_q <= 32'h0000_0000;
        else
        begin
            unique case (mov_sel)
                PCF_SEL_CR0: mov_rdata_q <= cr0_q;
                PCF_SEL_CR3: mov_rdata_q <= cr3_q;
                PCF_SEL_CR4: mov_rdata_q <= cr4_q;
                PCF_SEL_NONE: mov_rdata_q <= 32'h0000_0000;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // flag aliases
    // ----------------------------------------------------------------
    logic emulate_fp;
    logic monitor_coproc;
    logic task_switched_flag;
    logic numeric_error_report;
    logic paging_on;
    logic phys_addr_extension;

    assign emulate_fp = cr0_q[`PCF_CR0_EMULATE];
    assign monitor_coproc = cr0_q[`PCF_CR0_MONITOR];
    assign task_switched_flag = cr0_q[`PCF_CR0_TASK_SW];
    assign numeric_error_report = cr0_q[`PCF_CR0_NUMERR];
    assign paging_on = cr0_q[`PCF_CR0_PAGING];
    assign phys_addr_extension = cr4_q[`PCF_CR4_PAE];

    // ----------------------------------------------------------------
    // instruction checks and faults
    // ----------------------------------------------------------------
    // priority: debug alias, fp emulation, privileged reads, alignment, then machine check
    pcf_fault_t fault_d;
    logic fp_trap;

    assign fp_trap = instr.is_fp & emulate_fp;

    always_comb
    begin
        fault_d = '0;
        if (instr.valid && instr.is_dr45 && cr4_q[`PCF_CR4_DE])
            fault_d = '{valid: 1'b1, vector: `PCF_VEC_UD};
        else if (instr.valid && fp_trap)
            fault_d = '{valid: 1'b1, vector: `PCF_VEC_NM};
        else if (instr.valid && instr.is_read_timestamp_instr && cr4_q[`PCF_CR4_TSD] && instr.cpl != 2'h0)
            fault_d = '{valid: 1'b1, vector: `PCF_VEC_UD};
        else if (instr.valid && instr.is_read_perf_counter_instr && !cr4_q[`PCF_CR4_PCE] && instr.cpl != 2'h0)
            fault_d = '{valid: 1'b1, vector: `PCF_VEC_UD};
        else if (instr.valid && misaligned && cr0_q[`PCF_CR0_ALIGN] && align_check_flag)
            fault_d = '{valid: 1'b1, vector: `PCF_VEC_AC};
        else if (hw_error && cr4_q[`PCF_CR4_MCE])
            fault_d = '{valid: 1'b1, vector: `PCF_VEC_MC};
    end

    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
            fault_q <= '0;
        else
            fault_q <= fault_d;
    end

    // waiting instructions look at the task flag only when monitoring
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
            wait_ts_fault_q <= 1'b0;
        else
            wait_ts_fault_q <= instr.valid & instr.is_wait & monitor_coproc
                & task_switched_flag;
    end

    // ----------------------------------------------------------------
    // control word after init
    // ----------------------------------------------------------------
    // the init marker is kept so a store before any init still floats high
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
            fpu_seen_q <= 1'b0;
        else if (instr.valid && instr.is_finit && !fp_trap)
            fpu_seen_q <= fpu_sync_q;
    end

    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
            fcw_q <= `PCF_FCW_NONE;
        else if (instr.valid && instr.is_fstcw && !fp_trap)
            fcw_q <= fpu_seen_q ? `PCF_FCW_INIT : `PCF_FCW_NONE;
    end

    // ----------------------------------------------------------------
    // tlb flush requests
    // ----------------------------------------------------------------
    logic base_wr;

    assign base_wr = mov_wr & (mov_sel == PCF_SEL_CR3);

    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            tlb_flush_q <= 1'b0;
            tlb_keep_global_q <= 1'b0;
        end
        else
        begin
            tlb_flush_q <= task_switch | base_wr;
            tlb_keep_global_q <= cr4_q[`PCF_CR4_PGE];
        end
    end

    // ----------------------------------------------------------------
    // derived controls
    // ----------------------------------------------------------------
    pcf_ctrl_t ctrl_d;

    always_comb
    begin
        ctrl_d.fp_to_fpu = ~emulate_fp;
        ctrl_d.cache_en = ~cr0_q[`PCF_CR0_CACHEOFF];
        ctrl_d.write_thru_en = ~cr0_q[`PCF_CR0_NOWT];
        ctrl_d.addr36_en = phys_addr_extension & paging_on;
        ctrl_d.pae_xlate = phys_addr_extension & paging_on;
        ctrl_d.page_4m = cr4_q[`PCF_CR4_PSE] & ~ctrl_d.pae_xlate;
        ctrl_d.page_2m = cr4_q[`PCF_CR4_PSE] & ctrl_d.pae_xlate;
        ctrl_d.vif_v86 = cr4_q[`PCF_CR4_VME];
        ctrl_d.vif_prot = cr4_q[`PCF_CR4_PVI];
        ctrl_d.wp_en = cr0_q[`PCF_CR0_WPROT];
        ctrl_d.numerr_native = numeric_error_report;
        ctrl_d.mc_en = cr4_q[`PCF_CR4_MCE];
    end

    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
            ctrl_q <= '0;
        else
            ctrl_q <= ctrl_d;
    end

    // ----------------------------------------------------------------
    // page attribute pins
    // ----------------------------------------------------------------
    // outside unpaged cycles the pins are left to the paging unit
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            pins_oe_q <= 1'b0;
            page_cache_pin_q <= 1'b0;
            write_through_pin_q <= 1'b0;
        end
        else
        begin
            pins_oe_q <= paging_on & unpaged_cycle;
            page_cache_pin_q <= paging_on & unpaged_cycle & cr3_q[`PCF_CR3_PCD];
            write_through_pin_q <= paging_on & unpaged_cycle & cr3_q[`PCF_CR3_PWT];
        end
    end

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    a_fp_trap_vec: assert property (@(posedge sys_clk) disable iff (sys_rst)
        instr.valid && instr.is_fp && emulate_fp && !instr.is_dr45
        |=> fault_q.valid && fault_q.vector == 8'h07)
        else $error("emulated fp did not fault on vector 7");
    a_fp_pass: assert property (@(posedge sys_clk) disable iff (sys_rst)
        !emulate_fp |=> ctrl_q.fp_to_fpu)
        else $error("fp not routed to fpu");
    a_wait_test: assert property (@(posedge sys_clk) disable iff (sys_rst)
        !monitor_coproc |=> !wait_ts_fault_q)
        else $error("wait tested task flag without monitor");
    a_cr4_reset: assert property (@(posedge sys_clk)
        sys_rst |=> cr4_q == 32'h0)
        else $error("extension register not cleared");
    a_dr_alias_ud: assert property (@(posedge sys_clk) disable iff (sys_rst)
        instr.valid && instr.is_dr45 && cr4_q[3] |=> fault_q.valid && fault_q.vector == 8'h06)
        else $error("debug alias did not fault");
    a_tsd_level: assert property (@(posedge sys_clk) disable iff (sys_rst)
        instr.valid && instr.is_read_timestamp_instr && !cr4_q[2] && !instr.is_dr45 && !fp_trap && !instr.is_read_perf_counter_instr
        && !misaligned && !hw_error |=> !fault_q.valid)
        else $error("timestamp refused while enabled");
    a_mc_gate: assert property (@(posedge sys_clk) disable iff (sys_rst)
        !cr4_q[6] |=> fault_q.vector != 8'h12 || !fault_q.valid)
        else $error("machine check while disabled");
    a_pin_drive: assert property (@(posedge sys_clk) disable iff (sys_rst)
        paging_on && unpaged_cycle ##1 $stable(cr3_q) |-> pins_oe_q
        && page_cache_pin_q == cr3_q[4] && write_through_pin_q == cr3_q[3])
        else $error("page pins not driven");
    a_pae_paging: assert property (@(posedge sys_clk) disable iff (sys_rst)
        !paging_on |=> !ctrl_q.addr36_en)
        else $error("address extension without paging");
    a_fcw_init: assert property (@(posedge sys_clk) disable iff (sys_rst)
        instr.valid && instr.is_fstcw && !fp_trap |=>
        fcw_q == (fpu_seen_q ? 16'h037f : 16'hffff))
        else $error("control word wrong");
    // flag copies lag the registers by one cycle; reset cycles are skipped by the disable
    a_flush_keep: assert property (@(posedge sys_clk) disable iff (sys_rst)
        task_switch || base_wr
        |=> tlb_flush_q && tlb_keep_global_q == $past(cr4_q[`PCF_CR4_PGE]))
        else $error("tlb flush or global keep wrong");
    a_perf_open: assert property (@(posedge sys_clk) disable iff (sys_rst)
        instr.valid && instr.is_read_perf_counter_instr && cr4_q[`PCF_CR4_PCE] && !instr.is_dr45 && !fp_trap
        && !instr.is_read_timestamp_instr && !misaligned && !hw_error |=> !fault_q.valid)
        else $error("counter read refused while enabled");
    a_mc_raise: assert property (@(posedge sys_clk) disable iff (sys_rst)
        hw_error && cr4_q[`PCF_CR4_MCE] && !instr.valid
        |=> fault_q.valid && fault_q.vector == 8'h12)
        else $error("machine check not raised");
    a_addr_wide: assert property (@(posedge sys_clk) disable iff (sys_rst)
        phys_addr_extension && paging_on |=> ctrl_q.addr36_en)
        else $error("address extension not enabled");
    a_page_size: assert property (@(posedge sys_clk) disable iff (sys_rst)
        1'b1 |=>
        ctrl_q.page_4m == $past(cr4_q[`PCF_CR4_PSE] & ~(phys_addr_extension & paging_on))
        && ctrl_q.page_2m == $past(cr4_q[`PCF_CR4_PSE] & phys_addr_extension & paging_on))
        else $error("page size selection wrong");
    a_cache_bits: assert property (@(posedge sys_clk) disable iff (sys_rst)
        1'b1 |=> ctrl_q.cache_en == !$past(cr0_q[`PCF_CR0_CACHEOFF])
        && ctrl_q.write_thru_en == !$past(cr0_q[`PCF_CR0_NOWT]))
        else $error("cache control bits wrong");
    a_vif_bits: assert property (@(posedge sys_clk) disable iff (sys_rst)
        1'b1 |=> ctrl_q.vif_v86 == $past(cr4_q[`PCF_CR4_VME])
        && ctrl_q.vif_prot == $past(cr4_q[`PCF_CR4_PVI]))
        else $error("virtual interrupt enables wrong");
    a_wp_numerr: assert property (@(posedge sys_clk) disable iff (sys_rst)
        1'b1 |=> ctrl_q.wp_en == $past(cr0_q[`PCF_CR0_WPROT])
        && ctrl_q.numerr_native == $past(cr0_q[`PCF_CR0_NUMERR]))
        else $error("protect or numeric report bit wrong");
    a_pins_idle: assert property (@(posedge sys_clk) disable iff (sys_rst)
        !(paging_on && unpaged_cycle)
        |=> !pins_oe_q && !page_cache_pin_q && !write_through_pin_q)
        else $error("page pins driven outside unpaged cycles");
    c_fp_emul: cover property (@(posedge sys_clk) fault_q.vector == 8'h07 && fault_q.valid);
    c_flush_keep: cover property (@(posedge sys_clk) tlb_flush_q && tlb_keep_global_q);
    c_pins: cover property (@(posedge sys_clk) pins_oe_q && page_cache_pin_q);
    c_dr_alias: cover property (@(posedge sys_clk) fault_q.valid && fault_q.vector == 8'h06);
    c_wait_ts: cover property (@(posedge sys_clk) wait_ts_fault_q);

endmodule

//--- include/pcf_cfg.svh
`ifndef PCF_CFG_SVH
`define PCF_CFG_SVH
// control_reg_zero bit positions
`define PCF_CR0_PG_EN 0
`define PCF_CR0_MONITOR 1
`define PCF_CR0_EMULATE 2
`define PCF_CR0_TASK_SW 3
`define PCF_CR0_NUMERR 5
`define PCF_CR0_WPROT 16
`define PCF_CR0_ALIGN 18
`define PCF_CR0_NOWT 29
`define PCF_CR0_CACHEOFF 30
`define PCF_CR0_PAGING 31
// page_base_control_reg bit positions
`define PCF_CR3_PWT 3
`define PCF_CR3_PCD 4
// extension_control_reg bit positions
`define PCF_CR4_VME 0
`define PCF_CR4_PVI 1
`define PCF_CR4_TSD 2
`define PCF_CR4_DE 3
`define PCF_CR4_PSE 4
`define PCF_CR4_PAE 5
`define PCF_CR4_MCE 6
`define PCF_CR4_PGE 7
`define PCF_CR4_PCE 8
`define PCF_CR4_OSFX 9
`define PCF_CR4_OSXMM 10
// reset values and fixed codes
`define PCF_CR0_RST 32'h0000_0000
`define PCF_CR3_RST 32'h0000_0000
`define PCF_CR4_RST 32'h0000_0000
`define PCF_CR4_WMASK 32'h0000_07ff
`define PCF_VEC_NM 8'h07
`define PCF_VEC_UD 8'h06
`define PCF_VEC_MC 8'h12
`define PCF_VEC_AC 8'h11
`define PCF_FCW_NONE 16'hffff
`define PCF_FCW_INIT 16'h037f
`endif

//--- include/pcf_pkg.sv
package pcf_pkg;
    // control register selector on the move port
    typedef enum logic [1:0]
    {
        PCF_SEL_CR0 = 2'h0,
        PCF_SEL_CR3 = 2'h3,
        PCF_SEL_CR4 = 2'h2,
        PCF_SEL_NONE = 2'h1
    } pcf_sel_t;

    // one decoded instruction event from the front end
    typedef struct packed
    {
        logic valid;
        logic is_fp;
        logic is_wait;
        logic is_fstcw;
        logic is_finit;
        logic is_read_perf_counter_instr;
        logic is_read_timestamp_instr;
        logic is_dr45;
        logic [1:0] cpl;
    } pcf_instr_t;

    // fault report
    typedef struct packed
    {
        logic valid;
        logic [7:0] vector;
    } pcf_fault_t;

    // derived feature controls
    typedef struct packed
    {
        logic fp_to_fpu;
        logic cache_en;
        logic write_thru_en;
        logic addr36_en;
        logic pae_xlate;
        logic page_4m;
        logic page_2m;
        logic vif_v86;
        logic vif_prot;
        logic wp_en;
        logic numerr_native;
        logic mc_en;
    } pcf_ctrl_t;
endpackage

//--- dv/test_processor_control_flags.sv
`timescale 1ns/100ps
`include "pcf_cfg.svh"
module test_processor_control_flags
    import pcf_pkg::*;
;
    // ---------------------------------
    // design hookup and model state
    // ---------------------------------
    logic sys_clk, sys_rst, mov_wr, fpu_present, task_switch, hw_error;
    logic align_check_flag, misaligned, unpaged_cycle;
    pcf_sel_t mov_sel;
    logic [31:0] mov_wdata, mov_rdata_q, rng, cr0, cr3, cr4;
    pcf_instr_t instr;
    pcf_fault_t fault_q;
    pcf_ctrl_t ctrl_q;
    logic [15:0] fcw_q;
    logic wait_ts_fault_q, tlb_flush_q, tlb_keep_global_q;
    logic page_cache_pin_q, write_through_pin_q, pins_oe_q, fpu_m;
    int error_cnt, checks_done, cyc, k, c;
    int exp_q[$];
    pcf_flags pcf_flags_inst (.sys_clk(sys_clk), .sys_rst(sys_rst), .mov_wr(mov_wr),
        .mov_sel(mov_sel), .mov_wdata(mov_wdata), .mov_rdata_q(mov_rdata_q), .instr(instr),
        .fpu_present(fpu_present), .task_switch(task_switch), .hw_error(hw_error),
        .align_check_flag(align_check_flag), .misaligned(misaligned),
        .unpaged_cycle(unpaged_cycle), .fault_q(fault_q), .fcw_q(fcw_q),
        .wait_ts_fault_q(wait_ts_fault_q), .tlb_flush_q(tlb_flush_q),
        .tlb_keep_global_q(tlb_keep_global_q), .ctrl_q(ctrl_q),
        .page_cache_pin_q(page_cache_pin_q), .write_through_pin_q(write_through_pin_q),
        .pins_oe_q(pins_oe_q));
    // 4 ns clock
    initial
    begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end
    // hang guard, well above the few hundred cycles the run needs
    always @(posedge sys_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            error_cnt++;
            $display("CHECK FAILED t=%0t timeout", $time);
            test_done();
        end
    end
    // ---------------------------------
    // helpers
    // ---------------------------------
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    // kind 0 fp, 1 wait, 2 store word, 3 init, 4 perf read, 5 stamp read, 6 debug reg
    function automatic pcf_instr_t mk(input int kd, input int cp);
        return pcf_instr_t'({1'b1, 7'(7'h40 >> kd), 2'(cp)});
    endfunction
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks_done++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task test_done;
        $display("errors %0d checks %0d", error_cnt, checks_done);
        if (error_cnt == 0 && checks_done > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // move-to strobe, model follows; extension bits above 10 are dropped
    task automatic wr(input pcf_sel_t s, input logic [31:0] d);
        @(posedge sys_clk);
        mov_wr <= 1'b1;
        mov_sel <= s;
        mov_wdata <= d;
        @(posedge sys_clk);
        mov_wr <= 1'b0;
        if (s == PCF_SEL_CR0)
            cr0 = d;
        if (s == PCF_SEL_CR3)
            cr3 = d;
        if (s == PCF_SEL_CR4)
            cr4 = d & `PCF_CR4_WMASK;
    endtask
    // read data is registered from the previous select, so allow two edges
    task automatic rd(input pcf_sel_t s, input logic [31:0] e);
        @(posedge sys_clk);
        mov_sel <= s;
        repeat (2) @(posedge sys_clk);
        @(negedge sys_clk);
        cmp(mov_rdata_q, e, "read");
    endtask
    task automatic chk_ctrl;
        pcf_ctrl_t e, g;
        logic pa;
        repeat (2) @(posedge sys_clk);
        @(negedge sys_clk);
        pa = cr4[`PCF_CR4_PAE] & cr0[`PCF_CR0_PAGING];
        e = {~cr0[2], ~cr0[30], ~cr0[29], pa, pa, cr4[4] & ~pa, cr4[4] & pa, cr4[0], cr4[1],
            cr0[16], cr0[5], cr4[6]};
        g = ctrl_q;
        cmp(32'(g), 32'(e), "ctrl");
    endtask
    // one event cycle; outputs land one edge later
    task automatic ev(input pcf_instr_t i, input logic ts, input logic hw, input logic mis,
        input logic up);
        int v;
        @(posedge sys_clk);
        instr <= i;
        task_switch <= ts;
        hw_error <= hw;
        misaligned <= mis;
        unpaged_cycle <= up;
        @(posedge sys_clk);
        instr <= '0;
        task_switch <= 1'b0;
        hw_error <= 1'b0;
        misaligned <= 1'b0;
        unpaged_cycle <= 1'b0;
        v = -1;
        if (i.valid && i.is_dr45 && cr4[`PCF_CR4_DE])
            v = `PCF_VEC_UD;
        else if (i.valid && i.is_fp && cr0[`PCF_CR0_EMULATE])
            v = `PCF_VEC_NM;
        else if (i.valid && i.is_read_timestamp_instr && cr4[`PCF_CR4_TSD] && i.cpl != 0)
            v = `PCF_VEC_UD;
        else if (i.valid && i.is_read_perf_counter_instr && !cr4[`PCF_CR4_PCE] && i.cpl != 0)
            v = `PCF_VEC_UD;
        else if (i.valid && mis && align_check_flag && cr0[`PCF_CR0_ALIGN])
            v = `PCF_VEC_AC;
        else if (hw && cr4[`PCF_CR4_MCE])
            v = `PCF_VEC_MC;
        exp_q.push_back(v);
        if (i.valid && i.is_finit && !cr0[`PCF_CR0_EMULATE])
            fpu_m = fpu_present;
        @(negedge sys_clk);
        v = exp_q.pop_front();
        cmp(32'(fault_q.valid), 32'(v >= 0), "fault");
        if (v >= 0)
            cmp(32'(fault_q.vector), 32'(v), "vector");
        cmp(32'(wait_ts_fault_q), 32'(i.valid & i.is_wait & cr0[1] & cr0[3]), "wait");
        cmp(32'(tlb_flush_q), 32'(ts), "flush");
        if (ts)
            cmp(32'(tlb_keep_global_q), 32'(cr4[7]), "keep");
        if (i.valid && i.is_fstcw && !cr0[`PCF_CR0_EMULATE])
            cmp(32'(fcw_q), fpu_m ? 32'h037f : 32'hffff, "fcw");
        if (up)
            cmp(32'(pins_oe_q), 32'(cr0[31]), "oe");
        if (up)
            cmp(32'({page_cache_pin_q, write_through_pin_q}),
                32'(cr3[4:3] & {2{cr0[31]}}), "pins");
    endtask
    // ---------------------------------
    // main sequence
    // ---------------------------------
    initial
    begin
        {sys_rst, mov_wr, fpu_present, task_switch, hw_error} = 5'h10;
        {align_check_flag, misaligned, unpaged_cycle} = 3'h0;
        mov_sel = PCF_SEL_NONE;
        mov_wdata = 32'h0;
        instr = '0;
        {cr0, cr3, cr4, rng} = {96'h0, 32'h2d23};
        {error_cnt, checks_done, cyc, fpu_m} = '0;
        repeat (20) @(posedge sys_clk);
        sys_rst <= 1'b0;
        rd(PCF_SEL_CR4, 32'h0);
        cmp(32'(fcw_q), 32'hffff, "fcw reset");
        rd(PCF_SEL_NONE, 32'h0);
        // random register contents, reserved extension bits must read zero
        for (k = 0; k < 8; k++)
        begin
            rng = xs(rng);
            wr(PCF_SEL_CR4, rng);
            rd(PCF_SEL_CR4, cr4);
            rng = xs(rng);
            wr(PCF_SEL_CR0, rng & 32'he005_002f);
            chk_ctrl();
        end
        wr(PCF_SEL_CR0, 32'h8000_0001);
        wr(PCF_SEL_CR4, 32'h0000_0030);
        chk_ctrl();
        // every emulate/monitor pairing with the task-switched flag up
        for (k = 0; k < 4; k++)
        begin
            wr(PCF_SEL_CR0, 32'h28 | 32'(k << 1));
            ev(mk(0, 0), 0, 0, 0, 0);
            ev(mk(1, 0), 0, 0, 0, 0);
        end
        // coprocessor absent then present, settled through the synchroniser
        for (k = 0; k < 2; k++)
        begin
            @(posedge sys_clk);
            fpu_present <= 1'(k);
            wr(PCF_SEL_CR0, 32'h0);
            repeat (4) @(posedge sys_clk);
            ev(mk(3, 0), 0, 0, 0, 0);
            ev(mk(2, 0), 0, 0, 0, 0);
        end
        // privilege gating with the enables off then on
        for (k = 0; k < 2; k++)
        begin
            wr(PCF_SEL_CR4, k ? 32'h10c : 32'h0);
            for (c = 0; c < 4; c++)
            begin
                ev(mk(5, c), 0, 0, 0, 0);
                ev(mk(4, c), 0, 0, 0, 0);
                ev(mk(6, c), 0, 0, 0, 0);
            end
        end
        // alignment needs both flags; machine check needs its enable
        for (k = 0; k < 4; k++)
        begin
            wr(PCF_SEL_CR0, k[0] ? 32'h0004_0000 : 32'h0);
            align_check_flag <= k[1];
            wr(PCF_SEL_CR4, k[0] ? 32'h40 : 32'h0);
            ev(mk(1, 3), 0, 0, 1, 0);
            ev('0, 0, 1, 0, 0);
        end
        // flushes by task switch and by base register write
        for (k = 0; k < 2; k++)
        begin
            wr(PCF_SEL_CR4, k ? 32'h80 : 32'h0);
            ev('0, 1, 0, 0, 0);
            rng = xs(rng);
            wr(PCF_SEL_CR3, rng);
            @(negedge sys_clk);
            cmp(32'({tlb_flush_q, tlb_keep_global_q}), 32'({1'b1, cr4[7]}), "cr3 flush");
        end
        // second reset mid-run: global enable is set, so the clear is really seen
        @(posedge sys_clk);
        sys_rst <= 1'b1;
        repeat (3) @(posedge sys_clk);
        sys_rst <= 1'b0;
        {cr0, cr3, cr4, fpu_m} = '0;
        rd(PCF_SEL_CR4, 32'h0);
        cmp(32'(fcw_q), 32'hffff, "fcw after reset");
        // page pins on unpaged cycles, paging off and on
        for (k = 0; k < 4; k++)
        begin
            rng = xs(rng);
            wr(PCF_SEL_CR3, rng);
            wr(PCF_SEL_CR0, k[0] ? 32'h8000_0001 : 32'h0);
            ev('0, 0, 0, 0, 1);
        end
        test_done();
    end
endmodule
